/* File: cascade_timer_pkg.sv */
// Package: constants for the cascaded 32-bit event timer
package cascade_timer_pkg;
  localparam int          COUNT_WIDTH    = 32;
  localparam int          HALF_WIDTH     = 16;
  localparam int          FLAG_WIDTH     = 16;
  localparam int          VECTOR_WIDTH   = 8;
  localparam int          QUEUE_DEPTH    = 2;
  localparam logic [31:0] PERIOD_RESET   = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET     = 16'h0000;
  localparam logic [15:0] FLAG_RESET     = 16'h0000;
  localparam logic [15:0] CLEAR_ALL      = 16'hffff;
  localparam logic [7:0]  VECTOR_NONE    = 8'h00;
  localparam int          GROUP_COUNT    = 3;
  // Flag bit positions inside the group B flag register
  localparam int          FLAG_PERIOD_POS = 0;
  localparam int          FLAG_ZERO_POS   = 1;
  localparam int          FLAG_CAPTURE_POS = 2;
  typedef enum logic [1:0] {RUN_UP, RUN_DOWN, HOLD} run_state_type;
endpackage : cascade_timer_pkg

/* File: event_flag_group.sv */
// One interrupt flag group: write-ones clear, destructive vector read
`timescale 1ns/1ns
`default_nettype none
module event_flag_group
  import cascade_timer_pkg::*;
(
  input  wire logic                    core_clk,     // Device clock
  input  wire logic                    resetn,       // Async reset, low
  input  wire logic [FLAG_WIDTH-1:0]   flag_set,     // Event pulses
  input  wire logic [FLAG_WIDTH-1:0]   mask_in,      // Interrupt mask
  input  wire logic                    flag_wr,      // Write to flag register
  input  wire logic [FLAG_WIDTH-1:0]   flag_wdata,   // Ones clear flags
  input  wire logic                    vector_rd,    // Read of vector register
  output logic      [FLAG_WIDTH-1:0]   flags,        // Flag register
  output logic      [VECTOR_WIDTH-1:0] vector,       // Highest-priority pending vector
  output logic                         irq           // Any unmasked flag
);
  logic [FLAG_WIDTH-1:0] flags_q;
  logic [FLAG_WIDTH-1:0] flags_d;
  logic [FLAG_WIDTH-1:0] pend;
  logic [FLAG_WIDTH-1:0] top_bit;
  logic [VECTOR_WIDTH-1:0] vec_w;

  // Lowest pending unmasked bit has highest priority
  function automatic logic [VECTOR_WIDTH-1:0] prio_vec(input logic [FLAG_WIDTH-1:0] p);
    prio_vec = VECTOR_NONE;
    for (int i = FLAG_WIDTH - 1; i >= 0; i--)
      if (p[i])
        prio_vec = VECTOR_WIDTH'(i + 1);
  endfunction : prio_vec

  assign pend    = flags_q & mask_in;
  assign vec_w   = prio_vec(pend);
  assign top_bit = (vec_w == VECTOR_NONE) ? FLAG_RESET
                 : (FLAG_WIDTH'(1) << (vec_w - VECTOR_WIDTH'(1)));
  // Clears by one-write and by vector read; a new event wins over the clear
  assign flags_d = (flags_q & ~(flag_wr ? flag_wdata : FLAG_RESET) // [R07]
                   & ~(vector_rd ? top_bit : FLAG_RESET)) | flag_set; // [R08]

  // Flag storage
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      flags_q <= FLAG_RESET;
    else
      flags_q <= flags_d;
  end

  assign flags  = flags_q;
  assign vector = vec_w;
  assign irq    = |pend;
endmodule : event_flag_group
`default_nettype wire

/* File: cascade_event_timer.sv */
// Top: two 16-bit timers cascaded into a saturating 32-bit up/down counter
// Function
// [R01] Timers two and three join into one 32-bit counter.
// [R02] Counting up, counter stops and holds at the 32-bit period.
// [R03] Saturated counter restarts only on direction pin change, counting opposite way.
// [R04] Counting down, counter stops at zero until direction pin toggles.
// [R05] Halves have no shadow; software stops timer to read coherently.
// [R06] Reset clears counters, controls, capture queue and interrupt masks.
// [R07] Interrupt flags clear by writing ones; all-ones clears all.
// [R08] Reading vector or capture queue clears it and updates flags; a capture queue read here leaves the flags unchanged.
// [R09] Low half carries or borrows into high half; period compared whole.
`timescale 1ns/1ns
`default_nettype none
module cascade_event_timer
  import cascade_timer_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH           // Capture queue depth
)
(
  input  wire logic                       core_clk,        // 20 MHz clock
  input  wire logic                       resetn,          // Async reset, low
  input  wire logic                       count_direction_pin, // Direction pin
  input  wire logic                       capture_pin,     // Capture input pin
  input  wire logic                       timer_enable,    // Counting enable
  input  wire logic [COUNT_WIDTH-1:0]     period_in,       // 32-bit period
  input  wire logic                       period_load,     // Latch period_in
  input  wire logic [FLAG_WIDTH-1:0]      mask_b,          // Group B mask
  input  wire logic                       mask_load,       // Latch mask_b
  input  wire logic                       flag_b_wr,       // Write flag reg B
  input  wire logic [FLAG_WIDTH-1:0]      flag_b_wdata,    // Ones clear
  input  wire logic                       vector_b_rd,     // Read vector reg B
  input  wire logic                       queue_rd,        // Read capture queue
  output logic      [HALF_WIDTH-1:0]      timer_two_count, // Low half
  output logic      [HALF_WIDTH-1:0]      timer_three_count, // High half
  output logic                            count_up,        // Current direction
  output logic                            saturated,       // Counter holding
  output logic      [FLAG_WIDTH-1:0]      event_flag_reg_b, // Flags B
  output logic      [VECTOR_WIDTH-1:0]    event_vector_reg_b, // Vector B
  output logic      [HALF_WIDTH-1:0]      capture_queue_1, // Queue head
  output logic                            queue_valid,     // Queue not empty
  output logic                            irq_b            // Group B request
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic dir_s1_q;
  logic dir_s2_q;
  logic dir_last_q;
  logic cap_s1_q;
  logic cap_s2_q;
  logic cap_last_q;
  logic [2:0] warm_q;

  // Two flops per pin before any use
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dir_s1_q   <= 1'b0;
      dir_s2_q   <= 1'b0;
      dir_last_q <= 1'b0;
      cap_s1_q   <= 1'b0;
      cap_s2_q   <= 1'b0;
      cap_last_q <= 1'b0;
      warm_q     <= 3'h0;
    end
    else
    begin
      warm_q     <= {warm_q[1:0], 1'b1};
      dir_s1_q   <= count_direction_pin;
      dir_s2_q   <= dir_s1_q;
      dir_last_q <= dir_s2_q;
      cap_s1_q   <= capture_pin;
      cap_s2_q   <= cap_s1_q;
      cap_last_q <= cap_s2_q;
    end
  end

  logic dir_toggle;
  logic cap_edge;
  // Edges count only once both compared flops hold real pin samples,
  // so a pin held high through reset is not taken for a change
  assign dir_toggle = warm_q[2] & (dir_s2_q ^ dir_last_q);
  assign cap_edge   = warm_q[2] & cap_s2_q & ~cap_last_q;

  // ----------------------------------------------------------------
  // Cascaded counter
  // ----------------------------------------------------------------
  logic [HALF_WIDTH-1:0]  low_q;
  logic [HALF_WIDTH-1:0]  low_d;
  logic [HALF_WIDTH-1:0]  high_q;
  logic [HALF_WIDTH-1:0]  high_d;
  logic [COUNT_WIDTH-1:0] period_q;
  logic [FLAG_WIDTH-1:0]  mask_q;
  run_state_type          state_q;
  run_state_type          state_d;
  logic                   up_q;
  logic                   up_d;
  logic [COUNT_WIDTH-1:0] full_cnt;
  logic                   at_period;
  logic                   at_zero;
  logic                   low_carry;
  logic                   low_borrow;
  logic                   hit_period;
  logic                   hit_zero;

  assign full_cnt   = {high_q, low_q};                       // [R01]
  assign at_period  = (full_cnt >= period_q);                // [R09]
  assign at_zero    = (full_cnt == PERIOD_RESET);
  assign low_carry  = (low_q == {HALF_WIDTH{1'b1}});         // [R09]
  assign low_borrow = (low_q == HALF_RESET);                 // [R09]
  assign hit_period = (state_q == RUN_UP) && timer_enable && at_period;
  assign hit_zero   = (state_q == RUN_DOWN) && timer_enable && at_zero;

  // Direction and run/hold sequencing
  always_comb
  begin
    state_d = state_q;
    up_d    = up_q;
    case (state_q)
      RUN_UP:
        if (hit_period)
          state_d = HOLD;                                    // [R02]
      RUN_DOWN:
        if (hit_zero)
          state_d = HOLD;                                    // [R04]
      HOLD:
        if (dir_toggle)
        begin
          up_d    = ~up_q;                                   // [R03]
          state_d = up_q ? RUN_DOWN : RUN_UP;                // [R03]
        end
      default:
        state_d = HOLD;
    endcase
  end

  // Halves advance independently readable, no snapshot taken
  always_comb
  begin
    low_d  = low_q;
    high_d = high_q;
    if (timer_enable && state_q == RUN_UP && !at_period)
    begin
      low_d  = low_q + HALF_WIDTH'(1);
      high_d = low_carry ? high_q + HALF_WIDTH'(1) : high_q; // [R09]
    end
    else if (timer_enable && state_q == RUN_DOWN && !at_zero)
    begin
      low_d  = low_q - HALF_WIDTH'(1);
      high_d = low_borrow ? high_q - HALF_WIDTH'(1) : high_q; // [R09]
    end
  end

  // Counter, period and mask storage; all clear on reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_q    <= HALF_RESET;                                // [R06]
      high_q   <= HALF_RESET;                                // [R06]
      period_q <= PERIOD_RESET;                              // [R06]
      mask_q   <= FLAG_RESET;                                // [R06]
      state_q  <= RUN_UP;
      up_q     <= 1'b1;
    end
    else
    begin
      low_q    <= low_d;
      high_q   <= high_d;
      state_q  <= state_d;
      up_q     <= up_d;
      if (period_load)
        period_q <= period_in;
      if (mask_load)
        mask_q <= mask_b;
    end
  end

  // Live halves straight out; no shadow register between them
  assign timer_two_count   = low_q;                          // [R05]
  assign timer_three_count = high_q;                         // [R05]
  assign count_up          = up_q;
  assign saturated         = (state_q == HOLD);

  // ----------------------------------------------------------------
  // Capture queue
  // ----------------------------------------------------------------
  localparam int FILL_W = $clog2(DEPTH + 1);
  localparam int IDX_W  = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [HALF_WIDTH-1:0] queue_q [DEPTH];
  logic [FILL_W-1:0]     fill_q;
  logic [IDX_W-1:0]      push_idx;
  logic queue_full;
  logic pop;
  logic push;

  assign queue_full = (fill_q == FILL_W'(DEPTH));
  // Slot for a new capture; a pop in the same cycle moves it down one
  assign push_idx   = IDX_W'(pop ? fill_q - FILL_W'(1) : fill_q);
  assign pop        = queue_rd && (fill_q != '0);            // [R08]
  assign push       = cap_edge && !queue_full;

  // Shift queue: read removes head, capture appends low half
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fill_q <= '0;                                          // [R06]
      for (int i = 0; i < DEPTH; i++)
        queue_q[i] <= HALF_RESET;                            // [R06]
    end
    else
    begin
      if (pop)
        for (int i = 0; i < DEPTH - 1; i++)
          queue_q[i] <= queue_q[i+1];
      if (push)
        queue_q[push_idx] <= low_q;
      fill_q <= fill_q + FILL_W'(push) - FILL_W'(pop);
    end
  end

  assign capture_queue_1 = queue_q[0];
  assign queue_valid     = (fill_q != '0);

  // ----------------------------------------------------------------
  // Group B interrupt flags
  // ----------------------------------------------------------------
  logic [FLAG_WIDTH-1:0] set_b;
  always_comb
  begin
    set_b = FLAG_RESET;
    set_b[FLAG_PERIOD_POS]  = hit_period;
    set_b[FLAG_ZERO_POS]    = hit_zero;
    set_b[FLAG_CAPTURE_POS] = push;
  end

  event_flag_group u_flags_b (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .flag_set   (set_b),
    .mask_in    (mask_q),
    .flag_wr    (flag_b_wr),
    .flag_wdata (flag_b_wdata),
    .vector_rd  (vector_b_rd),
    .flags      (event_flag_reg_b),
    .vector     (event_vector_reg_b),
    .irq        (irq_b)
  );
endmodule : cascade_event_timer
`default_nettype wire

/* File: cascade_timer_assertions.sv */
// Port checks for the cascaded event timer
`timescale 1ns/1ns
`default_nettype none
module cascade_timer_checker #(
  parameter int DEPTH = 2 // Queue depth
)
(
  input wire logic        core_clk,           // Clock
  input wire logic        resetn,             // Reset, low
  input wire logic        timer_enable,       // Run
  input wire logic        flag_b_wr,          // Flag write
  input wire logic [15:0] flag_b_wdata,       // Ones clear
  input wire logic        vector_b_rd,        // Vector read
  input wire logic [15:0] timer_two_count,    // Low half
  input wire logic [15:0] timer_three_count,  // High half
  input wire logic        count_up,           // Direction
  input wire logic        saturated,          // Holding
  input wire logic [15:0] event_flag_reg_b,   // Flags
  input wire logic [7:0]  event_vector_reg_b, // Vector
  input wire logic        queue_valid,        // Queue not empty
  input wire logic        irq_b               // Request
);
  // Whole count and the bits a write clears
  wire logic [31:0] cnt = {timer_three_count, timer_two_count};
  wire logic [15:0] clr = flag_b_wr ? flag_b_wdata : 16'h0000;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ----------
  // Assertions
  // ----------
  chk_reset_state: assert property (
    $rose(resetn) |-> cnt == 32'h0 && count_up && !queue_valid && event_flag_reg_b == 16'h0)
    else $error("state after reset wrong");
  chk_up_step: assert property (
    $past(resetn) && $past(timer_enable) && $past(count_up) && !$past(saturated) && count_up
    |-> cnt == $past(cnt) + 32'h1 || saturated) else $error("up step wrong");
  chk_down_step: assert property (
    $past(resetn) && $past(timer_enable) && !$past(count_up) && !$past(saturated) && !count_up
    |-> cnt == $past(cnt) - 32'h1 || saturated) else $error("down step wrong");
  chk_hold_still: assert property (
    saturated && $past(saturated) |-> cnt == $past(cnt)) else $error("held count moved");
  chk_dir_change: assert property (
    $changed(count_up) |-> $past(saturated) || $past(saturated, 2))
    else $error("direction changed while running");
  chk_down_floor: assert property (
    saturated && !count_up |-> cnt == 32'h0) else $error("down hold not at zero");
  chk_irq_vector: assert property (
    irq_b == (event_vector_reg_b != 8'h00) && (!irq_b || event_flag_reg_b != 16'h0))
    else $error("request and vector disagree");
  chk_flag_keep: assert property (
    !vector_b_rd |=> ($past(event_flag_reg_b) & ~event_flag_reg_b & ~$past(clr)) == 16'h0)
    else $error("flag dropped without clear");
  chk_vector_pop: assert property (
    vector_b_rd && event_vector_reg_b != 8'h00
    |=> !event_flag_reg_b[$past(event_vector_reg_b) - 8'h01]) else $error("vector read kept flag");
endmodule : cascade_timer_checker
bind cascade_event_timer cascade_timer_checker #(.DEPTH(DEPTH)) watch (
  .core_clk(core_clk), .resetn(resetn), .timer_enable(timer_enable), .flag_b_wr(flag_b_wr),
  .flag_b_wdata(flag_b_wdata), .vector_b_rd(vector_b_rd), .timer_two_count(timer_two_count),
  .timer_three_count(timer_three_count), .count_up(count_up), .saturated(saturated),
  .event_flag_reg_b(event_flag_reg_b), .event_vector_reg_b(event_vector_reg_b),
  .queue_valid(queue_valid), .irq_b(irq_b));
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the cascaded event timer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cascade_timer_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, dir_pin = 1'b0, cap_pin = 1'b0, run = 1'b0;
  logic p_ld = 1'b0, m_ld = 1'b0, f_wr = 1'b0, v_rd = 1'b0, q_rd = 1'b0;
  logic [31:0] per = 32'h0;
  logic [15:0] mask = 16'h0, f_wd = 16'h0, lo, hi, flags, head;
  logic [7:0] vec;
  logic up, sat, qv, irq;
  int err_total = 0, cmp_count = 0, cyc = 0;
  wire logic [31:0] cnt = {hi, lo};
  cascade_event_timer #(.DEPTH(2)) dut (.core_clk(core_clk), .resetn(resetn),
    .count_direction_pin(dir_pin), .capture_pin(cap_pin), .timer_enable(run),
    .period_in(per), .period_load(p_ld), .mask_b(mask), .mask_load(m_ld),
    .flag_b_wr(f_wr), .flag_b_wdata(f_wd), .vector_b_rd(v_rd), .queue_rd(q_rd),
    .timer_two_count(lo), .timer_three_count(hi), .count_up(up), .saturated(sat),
    .event_flag_reg_b(flags), .event_vector_reg_b(vec), .capture_queue_1(head),
    .queue_valid(qv), .irq_b(irq));
  // -----
  // Tasks
  // -----
  always #25 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Cut a hang short
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total++;
      final_report;
    end
  end
  task automatic wait_sat(input logic lvl, input int lim);
    repeat (lim)
    begin
      @(negedge core_clk);
      if (sat === lvl)
        return;
    end
    chk("sat wait", lvl, sat);
  endtask : wait_sat
  task automatic load(input logic [31:0] p);
    @(posedge core_clk);
    per <= p;
    p_ld <= 1'b1;
    @(posedge core_clk);
    p_ld <= 1'b0;
    run <= 1'b1;
  endtask : load
  task automatic t_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    run <= 1'b0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk("count", 32'h0, cnt);
    chk("flags", 16'h0, flags);
    chk("dir", 1'b1, up);
    chk("queue", 1'b0, qv);
    $display("reset test done");
  endtask : t_reset
  task automatic t_up;
    load(32'h5);
    wait_sat(1'b1, 20);
    repeat (10) @(negedge core_clk);
    chk("up hold", 32'h5, cnt);
    chk("period flag", 16'h1, flags);
    $display("up test done");
  endtask : t_up
  task automatic t_reads;
    @(posedge core_clk);
    mask <= 16'h3;
    m_ld <= 1'b1;
    cap_pin <= 1'b1;
    @(posedge core_clk);
    m_ld <= 1'b0;
    @(negedge core_clk);
    chk("irq", 1'b1, irq);
    chk("vector", 8'h1, vec);
    repeat (6) @(posedge core_clk);
    cap_pin <= 1'b0;
    @(negedge core_clk);
    chk("queue head", 16'h5, head);
    chk("capture flag", 16'h5, flags);
    @(posedge core_clk);
    q_rd <= 1'b1;
    v_rd <= 1'b1;
    @(posedge core_clk);
    q_rd <= 1'b0;
    v_rd <= 1'b0;
    f_wr <= 1'b1;
    f_wd <= 16'h0;
    @(negedge core_clk);
    chk("queue pop", 1'b0, qv);
    chk("vector pop", 16'h4, flags);
    @(posedge core_clk);
    f_wd <= CLEAR_ALL;
    @(negedge core_clk);
    chk("zero write", 16'h4, flags);
    @(posedge core_clk);
    f_wr <= 1'b0;
    @(negedge core_clk);
    chk("ones write", 16'h0, flags);
    $display("read test done");
  endtask : t_reads
  task automatic t_down;
    @(posedge core_clk);
    dir_pin <= 1'b1;
    wait_sat(1'b0, 10);
    chk("dir down", 1'b0, up);
    wait_sat(1'b1, 20);
    repeat (5) @(negedge core_clk);
    chk("down hold", 32'h0, cnt);
    chk("zero flag", 16'h2, flags);
    // Toggle back: a counter held at zero restarts upwards
    @(posedge core_clk);
    dir_pin <= 1'b0;
    wait_sat(1'b0, 10);
    chk("dir up", 1'b1, up);
    chk("restart base", 32'h0, cnt);
    $display("down test done");
  endtask : t_down
  task automatic t_carry;
    t_reset;
    load(32'h0001_0001);
    repeat (10) @(posedge core_clk);
    run <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk("stopped", 32'ha, cnt);
    @(posedge core_clk);
    run <= 1'b1;
    wait_sat(1'b1, 66000);
    chk("high half", 16'h1, hi);
    chk("low half", 16'h1, lo);
    $display("carry test done");
  endtask : t_carry
  // Main sequence
  initial
  begin
    t_reset;
    t_up;
    t_reads;
    t_down;
    t_carry;
    final_report;
  end
endmodule : tb_top
`default_nettype wire
